// >>> src/bos_pkg.sv
// Notes on behaviour
// - the second byte after prefix ED selects single decrementing output (AB) or repeating decrementing output (BB).
// - prefix ED followed by B3 selects repeating output with an incrementing memory pointer.
// - each transfer first reads memory at the memory pointer pair and holds that byte until the output cycle.
// - the count is decremented after the memory read, and the output cycle drives port select on A0-A7 and the new count on A8-A15.
// - the low address byte picks one of 256 ports and the held byte is written to it on the data bus.
// - the incrementing repeating form adds one to the memory pointer pair after each byte is written.
// - the decrementing forms subtract one from the memory pointer pair as the last step of each transfer.
// - a repeating form whose new count is nonzero subtracts two from the program counter.
// - a repeating form whose new count is zero ends and moves on to the next instruction.
// - after each byte of a repeating form except the last, pending interrupts are taken and two refresh cycles are run.
// - a repeating form started with count zero wraps and moves 256 bytes.
// - a repeating pass that does not end takes 21 states split 4, 5, 3, 4, 5.
// - a single transfer, or the last pass of a repeat, takes 16 states split 4, 5, 3, 4.
// - the single form sets zero when the new count is zero and clears it otherwise, sets subtract, keeps carry.
// - a finished repeating form leaves zero and subtract set and carry unchanged.
package bos_pkg;
    localparam logic [7:0] BOS_OP_PREFIX = 8'hED;
    localparam logic [7:0] BOS_OP_DEC_SINGLE = 8'hAB;
    localparam logic [7:0] BOS_OP_DEC_REPEAT = 8'hBB;
    localparam logic [7:0] BOS_OP_INC_REPEAT = 8'hB3;

    // machine cycle lengths, then the refresh states within the repeat tail, in clock states, one state per clock
    localparam logic [2:0] BOS_T_OPC = 3'h4;
    localparam logic [2:0] BOS_T_OPC2 = 3'h5;
    localparam logic [2:0] BOS_T_MRD = 3'h3;
    localparam logic [2:0] BOS_T_IOWR = 3'h4;
    localparam logic [2:0] BOS_T_RPT = 3'h5;
    localparam logic [2:0] BOS_T_RFSH_A = 3'h0;
    localparam logic [2:0] BOS_T_RFSH_B = 3'h2;

    localparam logic [31:0] BOS_ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] BOS_ADDR_PTR = 32'h0000_0004;
    localparam logic [31:0] BOS_ADDR_CNT = 32'h0000_0008;
    localparam logic [31:0] BOS_ADDR_PORT = 32'h0000_000C;
    localparam logic [31:0] BOS_ADDR_PC = 32'h0000_0010;
    localparam logic [31:0] BOS_ADDR_FLAGS = 32'h0000_0014;
    localparam logic [31:0] BOS_ADDR_STATUS = 32'h0000_0018;

    localparam int BOS_CTRL_START_BIT = 16;
    localparam int BOS_FLAG_Z_BIT = 6;
    localparam int BOS_FLAG_N_BIT = 1;
    localparam int BOS_ST_BUSY_BIT = 0;
    localparam int BOS_ST_ILLEGAL_BIT = 1;
    localparam int BOS_ST_SUSP_BIT = 2;

    localparam logic [15:0] BOS_RST_OP = 16'h0000;
    localparam logic [15:0] BOS_RST_PTR = 16'h0000;
    localparam logic [7:0] BOS_RST_CNT = 8'h00;
    localparam logic [7:0] BOS_RST_PORT = 8'h00;
    localparam logic [15:0] BOS_RST_PC = 16'h0000;
    localparam logic [7:0] BOS_RST_FLAGS = 8'h00;

    localparam logic [1:0] BOS_RESP_OKAY = 2'h0;
    localparam logic [1:0] BOS_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {BOS_KIND_NONE, BOS_KIND_DEC_SINGLE, BOS_KIND_DEC_REPEAT,
        BOS_KIND_INC_REPEAT} bos_kind_type;

    typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_OPC2, ST_MRD, ST_IOWR, ST_RPT} bos_state_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
        logic mem_rd;
        logic io_wr;
        logic rfsh;
    } bos_bus_type;
endpackage : bos_pkg

// >>> src/bos_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module bos_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_idx;
    logic [AW-1:0] rd_idx;
    logic [AW:0] fill;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;

    assign in_ready_o = (fill < (AW+1)'(DEPTH));
    assign out_valid_o = (fill != '0);
    assign out_data_o = mem[rd_idx];

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem[wr_idx] <= in_data_i;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_idx <= '0;
            rd_idx <= '0;
            fill <= '0;
        end else begin
            if (push) begin
                wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
            end
            if (pop) begin
                rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
            end
            fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : bos_fifo
`default_nettype wire

// >>> src/bos_sequencer.sv
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module bos_sequencer import bos_pkg::*; #(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [31:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [31:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output bos_bus_type bus_o,
    input wire logic [7:0] data_i,
    input wire logic io_ready_i,
    input wire logic int_req_i,
    output logic int_ack_o
);
    bos_state_type state;
    bos_state_type next_state;
    bos_kind_type kind;
    logic [2:0] tcnt;
    logic [15:0] op;
    logic [15:0] memory_pointer_pair;
    logic [7:0] cnt;
    logic [7:0] port;
    logic [15:0] pc;
    logic [7:0] flags;
    logic illegal;
    logic suspended;
    logic [7:0] data_meta;
    logic [7:0] data_sync;
    logic [1:0] io_rdy_meta;
    logic [1:0] int_meta;
    logic [31:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic w_held;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;

    function automatic bos_kind_type decode_op(input logic [15:0] code);
        if (code[15:8] != BOS_OP_PREFIX) begin
            return BOS_KIND_NONE;
        end
        case (code[7:0])
            BOS_OP_DEC_SINGLE: return BOS_KIND_DEC_SINGLE;
            BOS_OP_DEC_REPEAT: return BOS_KIND_DEC_REPEAT;
            BOS_OP_INC_REPEAT: return BOS_KIND_INC_REPEAT;
            default: return BOS_KIND_NONE;
        endcase
    endfunction : decode_op

    // pins pass two flops before use; only the second stage is read
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            data_meta <= 8'h00;
            data_sync <= 8'h00;
            io_rdy_meta <= 2'h0;
            int_meta <= 2'h0;
        end else begin
            data_meta <= data_i;
            data_sync <= data_meta;
            io_rdy_meta <= {io_rdy_meta[0], io_ready_i};
            int_meta <= {int_meta[0], int_req_i};
        end
    end
    wire io_rdy_s = io_rdy_meta[1];
    wire int_s = int_meta[1];

    // register bus
    wire busy = (state != ST_IDLE);
    wire wr_fire = aw_held && w_held && !s_axi_bvalid_o;
    wire wr_ok = !busy;
    wire [15:0] wr_word = w_data[15:0];
    wire wr_ctrl = wr_fire && wr_ok && (aw_addr[7:0] == BOS_ADDR_CTRL[7:0]);
    wire wr_ptr = wr_fire && wr_ok && (aw_addr[7:0] == BOS_ADDR_PTR[7:0]);
    wire wr_cnt = wr_fire && wr_ok && (aw_addr[7:0] == BOS_ADDR_CNT[7:0]);
    wire wr_port = wr_fire && wr_ok && (aw_addr[7:0] == BOS_ADDR_PORT[7:0]);
    wire wr_pc = wr_fire && wr_ok && (aw_addr[7:0] == BOS_ADDR_PC[7:0]);
    wire wr_flags = wr_fire && wr_ok && (aw_addr[7:0] == BOS_ADDR_FLAGS[7:0]);
    wire wr_mapped = (aw_addr[31:5] == 27'h0) && (aw_addr[1:0] == 2'h0)
        && (aw_addr[4:2] != 3'h7);
    wire start_req = wr_ctrl && w_data[BOS_CTRL_START_BIT];
    wire bos_kind_type start_kind = decode_op(wr_word);

    assign s_axi_awready_o = !aw_held;
    assign s_axi_wready_o = !w_held;
    assign s_axi_arready_o = !s_axi_rvalid_o;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 32'h0000_0000;
            w_data <= 32'h0000_0000;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= BOS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && !w_held) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_i;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= wr_mapped ? BOS_RESP_OKAY : BOS_RESP_SLVERR;
            end else if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    wire [7:0] status = {5'h00, suspended, illegal, busy};
    always_comb begin
        rresp = BOS_RESP_OKAY;
        case (s_axi_araddr_i)
            BOS_ADDR_CTRL: rdata = {16'h0000, op};
            BOS_ADDR_PTR: rdata = {16'h0000, memory_pointer_pair};
            BOS_ADDR_CNT: rdata = {24'h000000, cnt};
            BOS_ADDR_PORT: rdata = {24'h000000, port};
            BOS_ADDR_PC: rdata = {16'h0000, pc};
            BOS_ADDR_FLAGS: rdata = {24'h000000, flags};
            BOS_ADDR_STATUS: rdata = {24'h000000, status};
            default: begin
                rdata = 32'h0000_0000;
                rresp = BOS_RESP_SLVERR;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= BOS_RESP_OKAY;
        end else if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= rdata;
            s_axi_rresp_o <= rresp;
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    // sequencing: one clock per state
    logic [2:0] tlen;
    always_comb begin
        case (state)
            ST_OPC: tlen = BOS_T_OPC;
            ST_OPC2: tlen = BOS_T_OPC2;
            ST_MRD: tlen = BOS_T_MRD;
            ST_IOWR: tlen = BOS_T_IOWR;
            ST_RPT: tlen = BOS_T_RPT;
            default: tlen = 3'h1;
        endcase
    end
    wire last_t = (tcnt == tlen - 3'h1);
    wire repeating = (kind != BOS_KIND_DEC_SINGLE);
    // the byte is pushed only once the fifo can take it, so a full fifo stalls the read
    wire mrd_done = (state == ST_MRD) && last_t && fifo_in_ready;
    // a slow peripheral or a missing byte stretches the output cycle
    wire iow_done = (state == ST_IOWR) && last_t && fifo_out_valid && io_rdy_s;
    wire again = repeating && (cnt != 8'h00);
    wire rpt_done = (state == ST_RPT) && last_t;
    wire hold_t = ((state == ST_MRD) && last_t && !fifo_in_ready)
        || ((state == ST_IOWR) && last_t && !iow_done);

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start_req && (start_kind != BOS_KIND_NONE)) begin
                    next_state = ST_OPC;
                end
            end
            ST_OPC: next_state = last_t ? ST_OPC2 : ST_OPC;
            ST_OPC2: next_state = last_t ? ST_MRD : ST_OPC2;
            ST_MRD: next_state = mrd_done ? ST_IOWR : ST_MRD;
            ST_IOWR: begin
                if (iow_done) begin
                    next_state = again ? ST_RPT : ST_IDLE;
                end
            end
            ST_RPT: begin
                if (rpt_done) begin
                    next_state = int_s ? ST_IDLE : ST_OPC;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= ST_IDLE;
            tcnt <= 3'h0;
        end else begin
            state <= next_state;
            tcnt <= (next_state != state) ? 3'h0 : (hold_t ? tcnt : tcnt + 3'h1);
        end
    end

    // architectural registers, written by software only while idle
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            op <= BOS_RST_OP;
            kind <= BOS_KIND_NONE;
            illegal <= 1'b0;
            suspended <= 1'b0;
            int_ack_o <= 1'b0;
            memory_pointer_pair <= BOS_RST_PTR;
            cnt <= BOS_RST_CNT;
            port <= BOS_RST_PORT;
            pc <= BOS_RST_PC;
            flags <= BOS_RST_FLAGS;
        end else begin
            int_ack_o <= rpt_done && int_s;
            if (wr_ctrl) begin
                op <= wr_word;
                if (start_req) begin
                    kind <= start_kind;
                    illegal <= (start_kind == BOS_KIND_NONE);
                    suspended <= 1'b0;
                end
            end
            if (wr_ptr) begin
                memory_pointer_pair <= wr_word;
            end
            if (wr_cnt) begin
                cnt <= wr_word[7:0];
            end
            if (wr_port) begin
                port <= wr_word[7:0];
            end
            if (wr_pc) begin
                pc <= wr_word;
            end
            if (wr_flags) begin
                flags <= wr_word[7:0];
            end
            // each opcode byte fetch advances the program counter by one
            if ((state == ST_OPC || state == ST_OPC2) && last_t) begin
                pc <= pc + 16'h0001;
            end
            if (mrd_done) begin
                cnt <= cnt - 8'h01;
            end
            if (iow_done) begin
                if (kind == BOS_KIND_INC_REPEAT) begin
                    memory_pointer_pair <= memory_pointer_pair + 16'h0001;
                end else begin
                    memory_pointer_pair <= memory_pointer_pair - 16'h0001;
                end
                flags[BOS_FLAG_Z_BIT] <= (cnt == 8'h00);
                flags[BOS_FLAG_N_BIT] <= 1'b1;
                if (again) begin
                    pc <= pc - 16'h0002;
                end
            end
            // an interrupt leaves pc on the instruction so it resumes after service
            if (rpt_done && int_s) begin
                suspended <= 1'b1;
            end
        end
    end

    bos_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(mrd_done),
        .in_ready_o(fifo_in_ready),
        .in_data_i(data_sync),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(iow_done),
        .out_data_o(fifo_out_data)
    );

    // bus outputs from flops; memory and port cycles never overlap
    bos_bus_type next_bus;
    always_comb begin
        next_bus = '0;
        case (next_state)
            ST_OPC, ST_OPC2: next_bus.addr = pc;
            ST_MRD: begin
                next_bus.addr = memory_pointer_pair;
                next_bus.mem_rd = 1'b1;
            end
            ST_IOWR: begin
                next_bus.addr = {(state == ST_MRD) ? cnt - 8'h01 : cnt, port};
                next_bus.data = fifo_out_data;
                next_bus.io_wr = 1'b1;
            end
            default: next_bus = '0;
        endcase
        if (state == ST_MRD && next_state == ST_IOWR) begin
            next_bus.data = data_sync;
        end
        if (state == ST_IOWR && next_state == ST_RPT) begin
            next_bus.rfsh = 1'b1;
        end else if (state == ST_RPT && next_state == ST_RPT
                     && tcnt + 3'h1 == BOS_T_RFSH_B) begin
            next_bus.rfsh = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bus_o <= '0;
        end else begin
            bus_o <= next_bus;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    AST_DECODE: assert property ((state == ST_IDLE) && start_req
        && (start_kind != BOS_KIND_NONE) |=> state == ST_OPC)
        else $error("valid opcode did not start");
    AST_DECODE_BAD: assert property ((state == ST_IDLE) && start_req
        && (decode_op(wr_word) == BOS_KIND_NONE) |=> state == ST_IDLE && illegal)
        else $error("unknown opcode was not refused");
    AST_READ_FIRST: assert property (bus_o.io_wr |-> fifo_out_valid)
        else $error("output cycle without a fetched byte");
    AST_ADDR_HI: assert property (bus_o.io_wr |-> bus_o.addr == {cnt, port})
        else $error("port cycle address wrong");
    AST_IO_DATA: assert property (bus_o.io_wr |-> bus_o.data == fifo_out_data)
        else $error("port cycle data is not the held byte");
    AST_PTR_INC: assert property (iow_done && kind == BOS_KIND_INC_REPEAT
        |=> memory_pointer_pair == $past(memory_pointer_pair) + 16'h0001)
        else $error("pointer not incremented");
    AST_PTR_DEC: assert property (iow_done && kind != BOS_KIND_INC_REPEAT
        |=> memory_pointer_pair == $past(memory_pointer_pair) - 16'h0001)
        else $error("pointer not decremented");
    AST_PC_BACK: assert property (iow_done && again |=> pc == $past(pc) - 16'h0002)
        else $error("program counter not stepped back");
    AST_END: assert property (iow_done && cnt == 8'h00 |=> state == ST_IDLE)
        else $error("repeat did not end at zero");
    AST_RFSH: assert property ($rose(state == ST_RPT) |-> bus_o.rfsh ##1 !bus_o.rfsh
        ##1 bus_o.rfsh)
        else $error("two refresh cycles missing");
    AST_T_RPT: assert property ($rose(state == ST_RPT) |-> (state == ST_RPT)[*5]
        ##1 state != ST_RPT)
        else $error("repeat tail is not five states");
    AST_T_HEAD: assert property ($rose(state == ST_OPC) |-> (state == ST_OPC)[*4]
        ##1 (state == ST_OPC2)[*5] ##1 state == ST_MRD)
        else $error("opcode cycles are not 4 and 5 states");
    AST_FLAGS: assert property (iow_done |=> flags[BOS_FLAG_N_BIT]
        && flags[BOS_FLAG_Z_BIT] == ($past(cnt) == 8'h00) && flags[0] == $past(flags[0]))
        else $error("flag update wrong");
    AST_FLAGS_RPT: assert property (iow_done && repeating && !again
        |=> flags[BOS_FLAG_Z_BIT] && flags[BOS_FLAG_N_BIT])
        else $error("finished repeat did not leave zero set");
    AST_IO_EXCL: assert property (!(bus_o.io_wr && bus_o.mem_rd))
        else $error("memory and port cycles overlap");

    COV_SINGLE: cover property (iow_done && kind == BOS_KIND_DEC_SINGLE);
    COV_REPEAT: cover property (rpt_done && !int_s);
    COV_INT: cover property (rpt_done && int_s);
    COV_WRAP: cover property (mrd_done && cnt == 8'h00);
endmodule : bos_sequencer
`default_nettype wire

// >>> test/bos_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module bos_mem_model import bos_pkg::*; (
    input wire logic clk_sys_i,
    input wire bos_bus_type bus_i,
    input wire logic slow_i,
    output logic [7:0] data_o,
    output logic io_ready_o
);
    logic [7:0] mem [0:65535];
    logic [31:0] cyc = 0;
    logic [2:0] wait_n = 0;
    logic io_q = 0;
    int n_rfsh = 0;
    logic [55:0] out_q [$];
    // off the read cycle the line is not driven: show the inverse, never a stale byte
    assign data_o = bus_i.mem_rd ? mem[bus_i.addr] : ~mem[bus_i.addr];
    assign io_ready_o = !(slow_i && wait_n != 3'h0);
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 32'h1;
        io_q <= bus_i.io_wr;
        if (bus_i.rfsh)
            n_rfsh <= n_rfsh + 1;
        if (bus_i.io_wr && !io_q) begin
            out_q.push_back({cyc, bus_i.addr, bus_i.data});
            wait_n <= 3'h3;
        end else if (wait_n != 3'h0) begin
            wait_n <= wait_n - 3'h1;
        end
    end
    initial begin
        for (int i = 0; i < 65536; i++)
            mem[i] = i[7:0];
    end
endmodule : bos_mem_model
`default_nettype wire

// >>> test/block_output_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module block_output_sequencer_tb import bos_pkg::*; ;
    logic clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, slow = 0, irq = 0;
    logic [31:0] awa = 0, wd = 0, ara = 0;
    wire logic awr, wr, bv, arr, rv, ior, iack;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdat;
    wire logic [7:0] din;
    wire bos_bus_type bus;
    int n_fail = 0, n_checks = 0, n_ack = 0;
    always #2 clk = ~clk;
    always @(posedge clk) begin
        if (iack)
            n_ack <= n_ack + 1;
    end
    bos_sequencer #(.FIFO_DEPTH(4)) u_dut (.clk_sys_i(clk), .sys_rst_i(rst),
        .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
        .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
        .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
        .s_axi_rready_i(rr), .bus_o(bus), .data_i(din), .io_ready_i(ior),
        .int_req_i(irq), .int_ack_o(iack));
    bos_mem_model u_mem (.clk_sys_i(clk), .bus_i(bus), .slow_i(slow), .data_o(din),
        .io_ready_o(ior));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
        awa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        fork
            begin @(posedge clk iff awr); awv <= 0; end
            begin @(posedge clk iff wr); wv <= 0; end
        join
        br <= 1;
        @(posedge clk iff bv);
        chk({30'h0, bresp}, {30'h0, BOS_RESP_OKAY});
        br <= 0;
    endtask : axi_wr
    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        ara <= a;
        arv <= 1;
        @(posedge clk iff arr);
        arv <= 0;
        rr <= 1;
        @(posedge clk iff rv);
        d = rdat;
        r = rresp;
        rr <= 0;
    endtask : axi_rd
    task automatic rchk(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk(d, e);
    endtask : rchk
    task automatic run(input logic [7:0] op, input logic [15:0] p, input logic [7:0] c);
        logic [31:0] d;
        logic [1:0] r;
        axi_wr(BOS_ADDR_PTR, {16'h0, p});
        axi_wr(BOS_ADDR_CNT, {24'h0, c});
        axi_wr(BOS_ADDR_PORT, 32'h07);
        axi_wr(BOS_ADDR_PC, 32'h0200);
        u_mem.out_q.delete();
        u_mem.n_rfsh = 0;
        axi_wr(BOS_ADDR_CTRL, {15'h0, 1'h1, BOS_OP_PREFIX, op});
        // polling keeps the bus busy, so the 256-byte run needs a wide bound
        for (int i = 0; i < 3000; i++) begin
            axi_rd(BOS_ADDR_STATUS, d, r);
            if (d[BOS_ST_BUSY_BIT] === 1'h0)
                break;
        end
        chk({31'h0, d[BOS_ST_BUSY_BIT]}, 32'h0);
    endtask : run
    task automatic t_single;
        u_mem.mem[16'h3000] = 8'h59;
        axi_wr(BOS_ADDR_FLAGS, 32'h01);
        slow <= 1;
        run(BOS_OP_DEC_SINGLE, 16'h3000, 8'h10);
        slow <= 0;
        chk(32'(u_mem.out_q.size()), 32'h1);
        chk({8'h0, u_mem.out_q[0][23:0]}, 32'h0F0759);
        rchk(BOS_ADDR_PTR, 32'h2FFF);
        rchk(BOS_ADDR_CNT, 32'h0F);
        rchk(BOS_ADDR_FLAGS, 32'h03);
        rchk(BOS_ADDR_PC, 32'h0202);
        run(BOS_OP_DEC_SINGLE, 16'h2FFF, 8'h01);
        chk({8'h0, u_mem.out_q[0][23:0]}, 32'h0007FF);
        rchk(BOS_ADDR_FLAGS, 32'h43);
    endtask : t_single
    task automatic t_rep(input logic [7:0] op, input logic [15:0] s);
        logic [15:0] a;
        run(op, 16'h1000, 8'h03);
        chk(32'(u_mem.out_q.size()), 32'h3);
        for (int i = 0; i < 3; i++) begin
            a = 16'h1000 + s * i[15:0];
            chk({8'h0, u_mem.out_q[i][23:0]}, {8'h0, 8'(2 - i), 8'h07, a[7:0]});
        end
        chk(u_mem.out_q[1][55:24] - u_mem.out_q[0][55:24], 32'h15);
        chk(32'(u_mem.n_rfsh), 32'h4);
        a = 16'h1000 + s * 16'h3;
        rchk(BOS_ADDR_PTR, {16'h0, a});
        rchk(BOS_ADDR_CNT, 32'h0);
        rchk(BOS_ADDR_FLAGS, 32'h43);
        rchk(BOS_ADDR_PC, 32'h0202);
    endtask : t_rep
    task automatic t_misc;
        logic [31:0] d;
        logic [1:0] r;
        run(BOS_OP_INC_REPEAT, 16'h2000, 8'h00);
        chk(32'(u_mem.out_q.size()), 32'h100);
        rchk(BOS_ADDR_PTR, 32'h2100);
        run(8'hAC, 16'h2000, 8'h01);
        chk(32'(u_mem.out_q.size()), 32'h0);
        axi_rd(BOS_ADDR_STATUS, d, r);
        chk({31'h0, d[BOS_ST_ILLEGAL_BIT]}, 32'h1);
        axi_rd(32'h1C, d, r);
        chk({30'h0, r}, {30'h0, BOS_RESP_SLVERR});
        // a pending interrupt stops the repeat after its first byte and tail
        irq <= 1;
        run(BOS_OP_INC_REPEAT, 16'h2000, 8'h03);
        irq <= 0;
        chk(32'(u_mem.out_q.size()), 32'h1);
        chk(32'(u_mem.n_rfsh), 32'h2);
        chk(32'(n_ack), 32'h1);
        rchk(BOS_ADDR_STATUS, 32'h4);
        rchk(BOS_ADDR_PC, 32'h0200);
        rchk(BOS_ADDR_CNT, 32'h02);
    endtask : t_misc
    task automatic finish_test;
        if (n_fail == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        t_single;
        t_rep(BOS_OP_INC_REPEAT, 16'h0001);
        t_rep(BOS_OP_DEC_REPEAT, 16'hFFFF);
        t_misc;
        finish_test;
    end
    initial begin
        #200000;
        n_fail++;
        finish_test;
    end
endmodule : block_output_sequencer_tb
`default_nettype wire
